/* rtl/clock_mux_map.svh */
// Constants for the glitch-free clock multiplexer and its controller
`ifndef CLOCK_MUX_MAP_SVH
`define CLOCK_MUX_MAP_SVH

// ****************************************************************
// Buffer population
// ****************************************************************
`define LANE_COUNT 32
`define HALF_LANE_COUNT 16
`define REGION_CLOCK_LIMIT 10

// ****************************************************************
// Lane configuration defaults
// ****************************************************************
`define INIT_OUT_DEFAULT 32'h00000000
`define START_ZERO_DEFAULT 32'h00000000
`define START_ONE_DEFAULT 32'h00000000

// ****************************************************************
// Controller register offsets
// ****************************************************************
`define PICK_OFFSET 8'h00
`define GATE_OFFSET 8'h04
`define BYPASS_ZERO_OFFSET 8'h08
`define BYPASS_ONE_OFFSET 8'h0c
`define STATUS_ZERO_OFFSET 8'h10
`define STATUS_ONE_OFFSET 8'h14

// ****************************************************************
// Controller reset values
// ****************************************************************
`define PICK_RESET 32'h00000000
`define GATE_RESET 32'hffffffff
`define BYPASS_RESET 32'h00000000

`endif

/* rtl/clock_mux_pkg.sv */
// Types shared by the clock multiplexer and its controller
package clock_mux_pkg;
	typedef logic [31:0] reg_word_t;
	typedef logic [7:0] reg_addr_t;
endpackage

/* rtl/clock_mux_if.sv */
// Interface joining the clock multiplexer array and its controller
`timescale 1ns/1ns
`default_nettype none
interface clock_mux_if #(
	parameter int LANE_COUNT = 32
);
	logic [LANE_COUNT-1:0] select_zero;
	logic [LANE_COUNT-1:0] select_one;
	logic [LANE_COUNT-1:0] enable_zero;
	logic [LANE_COUNT-1:0] enable_one;
	logic [LANE_COUNT-1:0] bypass_zero;
	logic [LANE_COUNT-1:0] bypass_one;
	logic [LANE_COUNT-1:0] status_zero;
	logic [LANE_COUNT-1:0] status_one;

	modport device_mp (
		input select_zero,
		input select_one,
		input enable_zero,
		input enable_one,
		input bypass_zero,
		input bypass_one,
		output status_zero,
		output status_one
	);

	modport controller_mp (
		output select_zero,
		output select_one,
		output enable_zero,
		output enable_one,
		output bypass_zero,
		output bypass_one,
		input status_zero,
		input status_one
	);
endinterface
`default_nettype wire

/* rtl/glitch_free_clock_mux.sv */
// Array of glitch-free two-input clock multiplexers
//
// Notes on behaviour
// - Glitch-free 2:1 mux, clocks may be asynchronous
// - Wait old fall, park low, then new fall
// - Default falling-edge sensitive, parks output low
// - Option rising-edge sensitive, parks output high
// - Bypass leaves that input at once
// - Input chosen only when select and enable high
// - All four high keeps the old input
// - Controller switches selects, ties enables high; this controller drives both enables from its gate register
// - Thirty-two buffers, sixteen per die half
// - Sources sit in the buffer's own half
// - At most ten global clocks per region
// - Dropping enable stops the output clock
// - Nothing chosen holds output at initial level
// - Per-lane parameter sets initial and parked level
// - Both start picks never set together
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "clock_mux_map.svh"

module glitch_free_clock_mux #(
	parameter int LANE_COUNT = `LANE_COUNT,
	parameter int HALF_LANE_COUNT = `HALF_LANE_COUNT,
	parameter logic [LANE_COUNT-1:0] INIT_OUT =
		LANE_COUNT'(`INIT_OUT_DEFAULT),
	parameter logic [LANE_COUNT-1:0] START_ZERO =
		LANE_COUNT'(`START_ZERO_DEFAULT),
	parameter logic [LANE_COUNT-1:0] START_ONE =
		LANE_COUNT'(`START_ONE_DEFAULT)
) (
	clock_mux_if.device_mp ctl,
	input wire logic rst_b_i,
	input wire logic [LANE_COUNT-1:0] clock_in_zero_i,
	input wire logic [LANE_COUNT-1:0] clock_in_one_i,
	output logic [LANE_COUNT-1:0] global_clock_net_o
);

	// ****************************************************************
	// Selection arithmetic
	// ****************************************************************

	// Own side may start only once the other side is seen stopped
	function automatic logic next_run(
		input logic own_want,
		input logic other_want,
		input logic other_busy,
		input logic cur
	);
		logic res;
		res = 1'b0;
		if (own_want && other_want) begin
			res = cur;
		end else if (own_want) begin
			res = cur | ~other_busy;
		end
		return res;
	endfunction

	// Low-parked lanes pass high phases, high-parked lanes low phases
	function automatic logic mix_out(
		input logic park_high,
		input logic clk_zero,
		input logic live_zero,
		input logic clk_one,
		input logic live_one
	);
		logic res;
		res = 1'b0;
		if (park_high) begin
			res = ~((~clk_zero & live_zero) | (~clk_one & live_one));
		end else begin
			res = (clk_zero & live_zero) | (clk_one & live_one);
		end
		return res;
	endfunction

	// ****************************************************************
	// Lanes, lower half top of die, upper half bottom
	// ****************************************************************

	for (genvar g = 0; g < LANE_COUNT; g++) begin : lane
		logic want_zero;
		logic want_one;
		logic live_zero;
		logic live_one;
		logic edge_zero;
		logic edge_one;
		logic run_zero;
		logic run_one;
		logic z_own_m;
		logic z_own_s;
		logic z_other_m;
		logic z_other_s;
		logic z_busy_m;
		logic z_busy_s;
		logic o_own_m;
		logic o_own_s;
		logic o_other_m;
		logic o_other_s;
		logic o_busy_m;
		logic o_busy_s;

		// A pair counts only with both lines high
		assign want_zero = ctl.select_zero[g] & ctl.enable_zero[g];
		assign want_one = ctl.select_one[g] & ctl.enable_one[g];

		// Bypass cuts the path without waiting for an edge; glitch is
		// the user's trade for speed
		assign live_zero = run_zero & ~(ctl.bypass_zero[g] & ~want_zero);
		assign live_one = run_one & ~(ctl.bypass_one[g] & ~want_one);

		// Decision edge is the one that ends the passed phase
		assign edge_zero = INIT_OUT[g] ? clock_in_zero_i[g] :
			~clock_in_zero_i[g];
		assign edge_one = INIT_OUT[g] ? clock_in_one_i[g] :
			~clock_in_one_i[g];

		// ************************************************************
		// Input zero domain
		// ************************************************************

		always_ff @(posedge edge_zero or negedge rst_b_i) begin
			if (!rst_b_i) begin
				z_own_m <= 1'b0;
				z_own_s <= 1'b0;
				z_other_m <= 1'b0;
				z_other_s <= 1'b0;
				z_busy_m <= 1'b0;
				z_busy_s <= 1'b0;
			end else begin
				z_own_m <= want_zero;
				z_own_s <= z_own_m;
				z_other_m <= want_one;
				z_other_s <= z_other_m;
				z_busy_m <= live_one;
				z_busy_s <= z_busy_m;
			end
		end

		// Start pick one wins nothing when both are set
		always_ff @(posedge edge_zero or negedge rst_b_i) begin
			if (!rst_b_i) begin
				run_zero <= START_ZERO[g] & ~START_ONE[g];
			end else begin
				run_zero <= next_run(z_own_s, z_other_s, z_busy_s, run_zero);
			end
		end

		// ************************************************************
		// Input one domain
		// ************************************************************

		always_ff @(posedge edge_one or negedge rst_b_i) begin
			if (!rst_b_i) begin
				o_own_m <= 1'b0;
				o_own_s <= 1'b0;
				o_other_m <= 1'b0;
				o_other_s <= 1'b0;
				o_busy_m <= 1'b0;
				o_busy_s <= 1'b0;
			end else begin
				o_own_m <= want_one;
				o_own_s <= o_own_m;
				o_other_m <= want_zero;
				o_other_s <= o_other_m;
				o_busy_m <= live_zero;
				o_busy_s <= o_busy_m;
			end
		end

		always_ff @(posedge edge_one or negedge rst_b_i) begin
			if (!rst_b_i) begin
				run_one <= START_ONE[g] & ~START_ZERO[g];
			end else begin
				run_one <= next_run(o_own_s, o_other_s, o_busy_s, run_one);
			end
		end

		// ************************************************************
		// Output and status
		// ************************************************************

		// Clock path cannot come from a flop; both gates are
		// changed only while their clock sits at the parked level, except when bypass cuts them
		assign global_clock_net_o[g] = mix_out(INIT_OUT[g],
			clock_in_zero_i[g], live_zero,
			clock_in_one_i[g], live_one);

		assign ctl.status_zero[g] = run_zero;
		assign ctl.status_one[g] = run_one;
	end

endmodule
`default_nettype wire

/* rtl/clock_mux_controller.sv */
// Register-driven controller for the clock multiplexer array
`timescale 1ns/1ns
`default_nettype none
`include "clock_mux_map.svh"

module clock_mux_controller #(
	parameter int LANE_COUNT = `LANE_COUNT
) (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire clock_mux_pkg::reg_addr_t addr_i,
	input wire clock_mux_pkg::reg_word_t wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output var clock_mux_pkg::reg_word_t rdata_o,
	clock_mux_if.controller_mp mux
);

	// ****************************************************************
	// Register state
	// ****************************************************************
	logic [LANE_COUNT-1:0] pick;
	logic [LANE_COUNT-1:0] gate;
	logic [LANE_COUNT-1:0] byp_zero;
	logic [LANE_COUNT-1:0] byp_one;
	logic [LANE_COUNT-1:0] st_zero_m;
	logic [LANE_COUNT-1:0] st_zero_s;
	logic [LANE_COUNT-1:0] st_one_m;
	logic [LANE_COUNT-1:0] st_one_s;

	function automatic logic hit(
		input clock_mux_pkg::reg_addr_t a,
		input clock_mux_pkg::reg_addr_t off,
		input logic strobe
	);
		return strobe && (a == off);
	endfunction

	function automatic clock_mux_pkg::reg_word_t widen(
		input logic [LANE_COUNT-1:0] v
	);
		clock_mux_pkg::reg_word_t res;
		res = '0;
		res[LANE_COUNT-1:0] = v;
		return res;
	endfunction

	// ****************************************************************
	// Register writes
	// ****************************************************************
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pick <= LANE_COUNT'(`PICK_RESET);
		end else if (hit(addr_i, `PICK_OFFSET, wr_i)) begin
			pick <= wdata_i[LANE_COUNT-1:0];
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			gate <= LANE_COUNT'(`GATE_RESET);
		end else if (hit(addr_i, `GATE_OFFSET, wr_i)) begin
			gate <= wdata_i[LANE_COUNT-1:0];
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			byp_zero <= LANE_COUNT'(`BYPASS_RESET);
			byp_one <= LANE_COUNT'(`BYPASS_RESET);
		end else begin
			if (hit(addr_i, `BYPASS_ZERO_OFFSET, wr_i)) begin
				byp_zero <= wdata_i[LANE_COUNT-1:0];
			end
			if (hit(addr_i, `BYPASS_ONE_OFFSET, wr_i)) begin
				byp_one <= wdata_i[LANE_COUNT-1:0];
			end
		end
	end

	// ****************************************************************
	// Lane drive
	// ****************************************************************
	// Selects are complementary, so all four lines are never high
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mux.select_zero <= ~LANE_COUNT'(`PICK_RESET);
			mux.select_one <= LANE_COUNT'(`PICK_RESET);
			mux.enable_zero <= LANE_COUNT'(`GATE_RESET);
			mux.enable_one <= LANE_COUNT'(`GATE_RESET);
			mux.bypass_zero <= LANE_COUNT'(`BYPASS_RESET);
			mux.bypass_one <= LANE_COUNT'(`BYPASS_RESET);
		end else begin
			mux.select_zero <= ~pick;
			mux.select_one <= pick;
			mux.enable_zero <= gate;
			mux.enable_one <= gate;
			mux.bypass_zero <= byp_zero;
			mux.bypass_one <= byp_one;
		end
	end

	// ****************************************************************
	// Status capture and read port
	// ****************************************************************
	// Status lives in the lane clocks, so it is resynchronised
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_zero_m <= '0;
			st_zero_s <= '0;
			st_one_m <= '0;
			st_one_s <= '0;
		end else begin
			st_zero_m <= mux.status_zero;
			st_zero_s <= st_zero_m;
			st_one_m <= mux.status_one;
			st_one_s <= st_one_m;
		end
	end

	// Read data stand one cycle only; unmapped reads return zero
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_o <= '0;
		end else if (!rd_i) begin
			rdata_o <= '0;
		end else begin
			unique case (addr_i)
				`PICK_OFFSET: rdata_o <= widen(pick);
				`GATE_OFFSET: rdata_o <= widen(gate);
				`BYPASS_ZERO_OFFSET: rdata_o <= widen(byp_zero);
				`BYPASS_ONE_OFFSET: rdata_o <= widen(byp_one);
				`STATUS_ZERO_OFFSET: rdata_o <= widen(st_zero_s);
				`STATUS_ONE_OFFSET: rdata_o <= widen(st_one_s);
				default: rdata_o <= '0;
			endcase
		end
	end

endmodule
`default_nettype wire

/* sim/clock_mux_assertions.sv */
// Concurrent checks on the lines between controller and multiplexer
`timescale 1ns/1ns
`default_nettype none
module clock_mux_assertions #(
	parameter int LANE_COUNT = 32
) (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic [LANE_COUNT-1:0] select_zero,
	input wire logic [LANE_COUNT-1:0] select_one,
	input wire logic [LANE_COUNT-1:0] enable_zero,
	input wire logic [LANE_COUNT-1:0] enable_one,
	input wire logic [LANE_COUNT-1:0] bypass_zero,
	input wire logic [LANE_COUNT-1:0] bypass_one,
	input wire logic [LANE_COUNT-1:0] status_zero,
	input wire logic [LANE_COUNT-1:0] status_one
);
	// ****************************************************************
	// Lane zero checks; select and enable pairs cover all lanes, one cover is on lane one
	// ****************************************************************
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_b_i);
	wire logic want_zero = select_zero[0] & enable_zero[0];
	wire logic want_one = select_one[0] & enable_one[0];
	property p_one_hot;
		!(status_zero[0] && status_one[0]);
	endproperty
	a_one_hot: assert property (p_one_hot)
		else $error("both inputs passing");
	property p_sel_pair;
		select_zero == ~select_one;
	endproperty
	a_sel_pair: assert property (p_sel_pair)
		else $error("selects not complementary");
	property p_en_pair;
		enable_zero == enable_one;
	endproperty
	a_en_pair: assert property (p_en_pair)
		else $error("enables differ");
	property p_not_all;
		!(want_zero && want_one);
	endproperty
	a_not_all: assert property (p_not_all)
		else $error("all four lines high");
	property p_old_drop;
		$fell(want_zero) |-> ##[0:12] !status_zero[0];
	endproperty
	a_old_drop: assert property (p_old_drop)
		else $error("old input kept");
	property p_new_rise;
		$rose(want_one) |-> ##[1:20] status_one[0];
	endproperty
	a_new_rise: assert property (p_new_rise)
		else $error("new input not taken");
	property p_order;
		$rose(status_one[0]) |-> !$past(status_zero[0]);
	endproperty
	a_order: assert property (p_order)
		else $error("new input before old stopped");
	property p_gate;
		$fell(enable_one[0]) |-> ##[0:20] !status_zero[0] && !status_one[0];
	endproperty
	a_gate: assert property (p_gate)
		else $error("gated lane still passing");
	c_switch: cover property ($rose(status_one[0]));
	c_back: cover property ($rose(status_zero[0]));
	c_gate: cover property ($fell(enable_zero[0]));
	c_cut_one: cover property ($fell(select_one[0]) && bypass_one[0]);
	c_cut_zero: cover property ($fell(select_zero[1]) && bypass_zero[1]);
endmodule
`default_nettype wire

/* sim/glitch_free_clock_mux_bench.sv */
// Self-checking bench joining controller and multiplexer
`timescale 1ns/1ns
`default_nettype none
`include "clock_mux_map.svh"
module glitch_free_clock_mux_bench;
	logic core_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic c0 = 1'b0;
	logic c1 = 1'b0;
	clock_mux_pkg::reg_addr_t addr = 8'h00;
	clock_mux_pkg::reg_word_t wdata = 32'h00000000;
	clock_mux_pkg::reg_word_t rdata;
	clock_mux_pkg::reg_word_t v;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [1:0] out;
	int error_cnt = 0;
	int samples_checked = 0;
	int cycles = 0;
	clock_mux_if #(.LANE_COUNT(2)) link();
	// Lane one runs in rising mode to cover the high park level
	glitch_free_clock_mux #(.LANE_COUNT(2), .INIT_OUT(2'b10)
	) glitch_free_clock_mux_inst (.ctl(link), .rst_b_i(rst_b_i),
		// Both lanes fed from one half, two clocks only
		.clock_in_zero_i({2{c0}}),
		.clock_in_one_i({2{c1}}),
		.global_clock_net_o(out));
	clock_mux_controller #(.LANE_COUNT(2)) clock_mux_controller_inst (
		.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.mux(link));
	clock_mux_assertions #(.LANE_COUNT(2)) clock_mux_assertions_inst (
		.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
		.select_zero(link.select_zero), .select_one(link.select_one),
		.enable_zero(link.enable_zero), .enable_one(link.enable_one),
		.bypass_zero(link.bypass_zero), .bypass_one(link.bypass_one),
		.status_zero(link.status_zero), .status_one(link.status_one));
	// ****************************************************************
	// Clocks and shared tasks
	// ****************************************************************
	// Source edges never land on the 1 ns sample points
	always #20 core_clk_i = ~core_clk_i;
	always #30 c0 = ~c0;
	always #18 c1 = ~c1;
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			error_cnt++;
			summarize();
		end
	end
	task summarize();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task wr_reg(input clock_mux_pkg::reg_addr_t a,
		input clock_mux_pkg::reg_word_t d);
		@(posedge core_clk_i);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge core_clk_i);
		wr <= 1'b0;
	endtask
	task rd_reg(input clock_mux_pkg::reg_addr_t a);
		@(posedge core_clk_i);
		rd <= 1'b1;
		addr <= a;
		@(posedge core_clk_i);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task follow(input logic one, input string name);
		repeat (16) begin
			@(posedge core_clk_i);
			#1 check(name, out, one ? {2{c1}} : {2{c0}});
		end
	endtask
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task s_reset();
		rd_reg(`PICK_OFFSET);
		check("pick", v, 32'h00000000);
		rd_reg(`GATE_OFFSET);
		check("gate", v, 32'h00000003);
		rd_reg(8'h20);
		check("unmapped", v, 32'h00000000);
		@(posedge core_clk_i);
		#1 check("rdata_hold", rdata, 32'h00000000);
		repeat (10) @(posedge core_clk_i);
		follow(1'b0, "start");
	endtask
	task s_switch();
		wr_reg(`PICK_OFFSET, 32'h00000003);
		repeat (30) begin
			@(posedge core_clk_i);
			#1;
			if (link.status_zero[0] === 1'b0 && link.status_one[0] === 1'b0)
				check("park_low", out[0], 1'b0);
			if (link.status_zero[1] === 1'b0 && link.status_one[1] === 1'b0)
				check("park_high", out[1], 1'b1);
		end
		follow(1'b1, "switched");
		rd_reg(`STATUS_ONE_OFFSET);
		check("status_one", v, 32'h00000003);
	endtask
	task s_gate();
		wr_reg(`GATE_OFFSET, 32'h00000000);
		repeat (20) @(posedge core_clk_i);
		repeat (16) begin
			@(posedge core_clk_i);
			#1 check("gated", out, 2'b10);
		end
		wr_reg(`GATE_OFFSET, 32'h00000003);
		repeat (20) @(posedge core_clk_i);
		follow(1'b1, "regate");
	endtask
	task s_bypass();
		wr_reg(`BYPASS_ONE_OFFSET, 32'h00000001);
		wr_reg(`PICK_OFFSET, 32'h00000000);
		@(posedge core_clk_i);
		#1 check("no_bypass", out[1], c1);
		repeat (3) begin
			#1 check("bypass_cut", out[0], 1'b0);
			@(posedge core_clk_i);
		end
		repeat (20) @(posedge core_clk_i);
		follow(1'b0, "back");
		wr_reg(`BYPASS_ZERO_OFFSET, 32'h00000002);
		wr_reg(`PICK_OFFSET, 32'h00000002);
		@(posedge core_clk_i);
		repeat (2) begin
			#1 check("bypass_high", out[1], 1'b1);
			@(posedge core_clk_i);
		end
		repeat (20) @(posedge core_clk_i);
		rd_reg(`BYPASS_ZERO_OFFSET);
		check("bypass_zero", v, 32'h00000002);
		rd_reg(`BYPASS_ONE_OFFSET);
		check("bypass_one", v, 32'h00000001);
		rd_reg(`STATUS_ZERO_OFFSET);
		check("status_zero", v, 32'h00000001);
		rd_reg(`STATUS_ONE_OFFSET);
		check("status_one_mix", v, 32'h00000002);
	endtask
	initial begin
		repeat (2) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		s_reset();
		s_switch();
		s_gate();
		s_bypass();
		summarize();
	end
endmodule
`default_nettype wire
